// ==== hw/rvs_top.sv ====
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "rvs_cfg.svh"
// Operation
// R1: opcode 40h or 41h starts verify
// R2: each sector read to buffer, ECC checked
// R3: DRQ never raised, no data out
// R4: sequenced like a normal sector read
// R5: uncorrectable error stops at failing sector
// R6: failing sector address left in registers
// R7: host sets mode, drive, head bits first
// R8: host loads start address bytes
// R9: host writes count; feature_select unused
// R10: final status BSY0 DRDY1 DWF0 DSC1 IDX0
// R11: error shows only UNC and IDNF
// R12: count keeps unverified sectors on error
// R13: start from address regs, run count
// R14: BSY held until results valid
module rvs_top #(
  parameter logic [7:0] SECTS_PER_TRACK = 8'h3F,
  parameter logic [3:0] HEAD_LAST       = 4'hF
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [7:0]              paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  output rvs_pkg::rvs_media_req_s      media_o,
  input  wire rvs_pkg::rvs_media_rsp_s media_i,
  output logic                         drq_o,
  output logic                         irq_o
);
  import rvs_pkg::*;

  // ==========================================================
  // state
  rvs_state_e     state_q;
  rvs_state_e     state_d;
  logic [7:0]     feat_q;
  logic [7:0]     cnt_q;
  logic [7:0]     lo_q;
  logic [7:0]     mid_q;
  logic [7:0]     hi_q;
  logic [7:0]     dh_q;
  logic [7:0]     err_q;
  logic           bsy_q;
  logic           corr_q;
  logic           fail_q;
  logic           retry_q;
  logic [8:0]     left_q;
  logic [1:0]     ists_q;
  logic [1:0]     imsk_q;
  logic           pready_q;
  logic           pslverr_q;
  logic [31:0]    prdata_q;
  rvs_media_req_s media_q;
  logic           irq_q;
  logic           drq_q;

  // ==========================================================
  // apb decode
  wire        acc_go   = psel_i & penable_i & ~pready_q;
  wire        acc_done = psel_i & penable_i & pready_q;
  wire        wr_acc   = acc_done & pwrite_i;
  wire        s_feat   = (paddr_i == `RVS_OFS_FEATURE);
  wire        s_cnt    = (paddr_i == `RVS_OFS_COUNT);
  wire        s_lo     = (paddr_i == `RVS_OFS_ADDR_LO);
  wire        s_mid    = (paddr_i == `RVS_OFS_ADDR_MID);
  wire        s_hi     = (paddr_i == `RVS_OFS_ADDR_HI);
  wire        s_dh     = (paddr_i == `RVS_OFS_DRV_HEAD);
  wire        s_cmd    = (paddr_i == `RVS_OFS_CMD_STAT);
  wire        s_err    = (paddr_i == `RVS_OFS_ERROR);
  wire        s_ists   = (paddr_i == `RVS_OFS_IRQ_STAT);
  wire        s_imsk   = (paddr_i == `RVS_OFS_IRQ_MASK);
  wire        mapped   = s_feat | s_cnt | s_lo | s_mid | s_hi | s_dh
                       | s_cmd | s_err | s_ists | s_imsk;
  // task file writes ignored while busy
  wire        tf_wr    = wr_acc & ~bsy_q;
  wire [7:0]  wbyte    = pwdata_i[7:0];
  // R1: verify opcodes start command
  wire        op_ok    = (wbyte == `RVS_OP_VERIFY_RTY)
                       | (wbyte == `RVS_OP_VERIFY_NRTY);
  wire        cmd_go   = tf_wr & s_cmd & op_ok;

  // ==========================================================
  // status and read mux
  logic [7:0] stat;
  always_comb
  begin
    stat                = 8'h00;
    // R10: fixed final status bits
    stat[`RVS_ST_BSY]   = bsy_q;
    stat[`RVS_ST_DRDY]  = 1'b1;
    stat[`RVS_ST_DWF]   = 1'b0;
    stat[`RVS_ST_DSC]   = 1'b1;
    // R3: DRQ reads zero
    stat[`RVS_ST_DRQ]   = 1'b0;
    stat[`RVS_ST_CORR]  = corr_q;
    stat[`RVS_ST_IDX]   = 1'b0;
    stat[`RVS_ST_ERR]   = fail_q;
  end

  wire [7:0] rbyte = s_cnt  ? cnt_q :
                     s_lo   ? lo_q :
                     s_mid  ? mid_q :
                     s_hi   ? hi_q :
                     s_dh   ? dh_q :
                     s_cmd  ? stat :
                     s_err  ? err_q :
                     s_ists ? {6'h00, ists_q} :
                     s_imsk ? {6'h00, imsk_q} : 8'h00;

  // ==========================================================
  // address stepping
  wire        lba_mode  = dh_q[`RVS_DH_LBA];
  wire [27:0] lba       = {dh_q[3:0], hi_q, mid_q, lo_q};
  wire [27:0] lba_nx    = lba + 28'h0000001;
  wire        sect_wrap = (lo_q == SECTS_PER_TRACK);
  wire        head_wrap = (dh_q[3:0] == HEAD_LAST);
  wire [15:0] cyl       = {hi_q, mid_q};
  wire [15:0] cyl_inc   = cyl + 16'h0001;
  wire [7:0]  chs_lo    = sect_wrap ? 8'h01 : lo_q + 8'h01;
  wire [3:0]  chs_head  = !sect_wrap ? dh_q[3:0] :
                          head_wrap  ? 4'h0 : dh_q[3:0] + 4'h1;
  wire [15:0] chs_cyl   = (sect_wrap & head_wrap) ? cyl_inc : cyl;
  // R4: same address stepping as read
  wire [27:0] step_nx   = lba_mode ? lba_nx
                                   : {chs_head, chs_cyl, chs_lo};

  // ==========================================================
  // media outcome
  wire        in_read   = (state_q == RVS_READ);
  wire        sec_done  = in_read & media_i.done;
  // R5: uncorrectable stops the run
  wire        sec_bad   = sec_done & (media_i.unc | media_i.idnf);
  wire        sec_good  = sec_done & ~sec_bad;
  wire        last_sec  = (left_q == 9'h001);
  // R13: run length from count register
  wire [8:0]  left_init = (cnt_q == 8'h00) ? 9'h100 : {1'b0, cnt_q};
  wire [8:0]  left_dec  = left_q - 9'h001;

  // ==========================================================
  // sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RVS_IDLE:
        if (cmd_go)
          state_d = RVS_READ;
      // R5: bad sector ends the run
      RVS_READ:
        if (sec_bad || (sec_good && last_sec))
          state_d = RVS_FINISH;
        else if (sec_good)
          state_d = RVS_GAP;
      RVS_GAP:
        state_d = RVS_READ;
      RVS_FINISH:
        state_d = RVS_IDLE;
      default:
        state_d = RVS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      state_q <= RVS_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // busy and outcome flags
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      bsy_q   <= 1'b0;
      corr_q  <= 1'b0;
      fail_q  <= 1'b0;
      err_q   <= `RVS_RST_BYTE;
      retry_q <= 1'b0;
      left_q  <= 9'h000;
    end
    else if (cmd_go)
    begin
      // R14: busy from command accept
      bsy_q   <= 1'b1;
      corr_q  <= 1'b0;
      fail_q  <= 1'b0;
      err_q   <= `RVS_RST_BYTE;
      retry_q <= (wbyte == `RVS_OP_VERIFY_RTY);
      left_q  <= left_init;
    end
    else if (state_q == RVS_FINISH)
      // R14: release once results stored
      bsy_q <= 1'b0;
    else if (sec_done)
    begin
      // R10: CORR and ERR follow outcome
      corr_q <= corr_q | media_i.corr;
      fail_q <= sec_bad;
      // R11: only UNC and IDNF reported
      err_q[`RVS_ER_UNC]  <= media_i.unc;
      err_q[`RVS_ER_IDNF] <= media_i.idnf & ~media_i.unc;
      // R12: one fewer left per good sector
      if (sec_good)
        left_q <= left_dec;
    end
  end

  // ==========================================================
  // task file registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      feat_q <= `RVS_RST_BYTE;
      cnt_q  <= `RVS_RST_BYTE;
      lo_q   <= `RVS_RST_BYTE;
      mid_q  <= `RVS_RST_BYTE;
      hi_q   <= `RVS_RST_BYTE;
      dh_q   <= `RVS_RST_BYTE;
    end
    else if (sec_good)
    begin
      // R12: count tracks unverified sectors
      cnt_q <= left_dec[7:0];
      // R6: address advances only past good sectors
      if (!last_sec)
      begin
        {dh_q[3:0], hi_q, mid_q, lo_q} <= step_nx;
      end
    end
    else if (tf_wr)
    begin
      // R9: feature_select stored, not used
      if (s_feat)
        feat_q <= wbyte;
      if (s_cnt)
        cnt_q <= wbyte;
      // R8: start address bytes
      if (s_lo)
        lo_q <= wbyte;
      if (s_mid)
        mid_q <= wbyte;
      if (s_hi)
        hi_q <= wbyte;
      // R7: mode, drive and head select
      if (s_dh)
        dh_q <= wbyte;
    end
  end

  // ==========================================================
  // media request
  // request only while reading, dropped once answered
  wire        req_d     = in_read & ~sec_done;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      media_q <= '0;
    else
    begin
      // R2: one buffer read per sector
      media_q.req      <= req_d;
      media_q.lba_mode <= lba_mode;
      media_q.retry    <= retry_q;
      media_q.drive    <= dh_q[`RVS_DH_DRV];
      media_q.cyl      <= cyl;
      media_q.head     <= dh_q[3:0];
      media_q.sect     <= lo_q;
    end
  end

  // ==========================================================
  // interrupts
  wire [1:0] ev_set = (state_q == RVS_FINISH) ? {fail_q, ~fail_q} : 2'h0;
  wire [1:0] ev_clr = (wr_acc & s_ists) ? pwdata_i[1:0] : 2'h0;
  // set wins over a same-cycle clear
  wire [1:0] ists_d = (ists_q & ~ev_clr) | ev_set;
  wire [1:0] imsk_d = (wr_acc & s_imsk) ? pwdata_i[1:0] : imsk_q;
  wire       irq_d  = |(ists_d & imsk_q);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ists_q <= `RVS_RST_IRQ;
      imsk_q <= `RVS_RST_IRQ;
    end
    else
    begin
      ists_q <= ists_d;
      imsk_q <= imsk_d;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  // ==========================================================
  // apb answer
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      drq_q     <= 1'b0;
    end
    else
    begin
      // one wait state, answer stands one cycle
      pready_q  <= acc_go;
      pslverr_q <= acc_go & ~mapped;
      prdata_q  <= (acc_go & ~pwrite_i) ? {24'h00_0000, rbyte} : 32'h0000_0000;
      // R3: no host data phase
      drq_q     <= 1'b0;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
  assign media_o   = media_q;
  assign drq_o     = drq_q;
  assign irq_o     = irq_q;

endmodule // rvs_top

// ==== shared/rvs_cfg.svh ====
`ifndef RVS_CFG_SVH
`define RVS_CFG_SVH

// ==========================================================
// register byte offsets
`define RVS_OFS_FEATURE   8'h00
`define RVS_OFS_COUNT     8'h04
`define RVS_OFS_ADDR_LO   8'h08
`define RVS_OFS_ADDR_MID  8'h0C
`define RVS_OFS_ADDR_HI   8'h10
`define RVS_OFS_DRV_HEAD  8'h14
`define RVS_OFS_CMD_STAT  8'h18
`define RVS_OFS_ERROR     8'h1C
`define RVS_OFS_IRQ_STAT  8'h20
`define RVS_OFS_IRQ_MASK  8'h24

// ==========================================================
// opcodes
`define RVS_OP_VERIFY_RTY  8'h40
`define RVS_OP_VERIFY_NRTY 8'h41

// ==========================================================
// field positions
`define RVS_ST_BSY   7
`define RVS_ST_DRDY  6
`define RVS_ST_DWF   5
`define RVS_ST_DSC   4
`define RVS_ST_DRQ   3
`define RVS_ST_CORR  2
`define RVS_ST_IDX   1
`define RVS_ST_ERR   0
`define RVS_ER_UNC   6
`define RVS_ER_IDNF  4
`define RVS_DH_LBA   6
`define RVS_DH_DRV   4
`define RVS_IRQ_DONE 0
`define RVS_IRQ_FAIL 1

// ==========================================================
// reset values
`define RVS_RST_BYTE 8'h00
`define RVS_RST_IRQ  2'h0

`endif

// ==== shared/rvs_pkg.sv ====
package rvs_pkg;

  // ==========================================================
  // media request and answer
  typedef struct packed {
    logic        req;
    logic        lba_mode;
    logic        retry;
    logic        drive;
    logic [15:0] cyl;
    logic [3:0]  head;
    logic [7:0]  sect;
  } rvs_media_req_s;

  typedef struct packed {
    logic done;
    logic unc;
    logic idnf;
    logic corr;
  } rvs_media_rsp_s;

  // ==========================================================
  // command sequencer states
  typedef enum logic [3:0] {
    RVS_IDLE   = 4'h1,
    RVS_READ   = 4'h2,
    RVS_GAP    = 4'h4,
    RVS_FINISH = 4'h8
  } rvs_state_e;

endpackage

// ==== dv/rvs_media_model.sv ====
`timescale 1ns/100ps
module rvs_media_model (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire rvs_pkg::rvs_media_req_s req_i,
  input  wire logic [27:0]             bad_i,
  input  wire logic [1:0]              kind_i,
  input  wire logic [3:0]              dly_i,
  output rvs_pkg::rvs_media_rsp_s      rsp_o
);
  import rvs_pkg::*;
  logic [3:0] cnt_q;
  logic       hit;
  logic       fire;
  assign hit  = {req_i.head, req_i.cyl, req_i.sect} == bad_i;
  assign fire = req_i.req && !rsp_o.done && cnt_q == dly_i;
  // ==========================================================
  // sector answers
  // one answer per sector, flags noisy when idle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 4'h0;
      rsp_o <= '0;
    end
    else
    begin
      cnt_q      <= fire || !req_i.req ? 4'h0 : cnt_q + 4'h1;
      rsp_o.done <= fire;
      rsp_o[2:0] <= fire ? 3'(hit) << (2'h3 - kind_i) : ~rsp_o[2:0];
    end
  end
endmodule // rvs_media_model

// ==== dv/rvs_top_assertions.sv ====
`timescale 1ns/100ps
`include "rvs_cfg.svh"
module rvs_chk (
  input wire logic                    ref_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [7:0]              paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic [31:0]             prdata_o,
  input wire logic                    pready_o,
  input wire logic                    pslverr_o,
  input wire rvs_pkg::rvs_media_req_s media_o,
  input wire rvs_pkg::rvs_media_rsp_s media_i,
  input wire logic                    drq_o,
  input wire logic                    irq_o
);
  import rvs_pkg::*;
  wire rd_ans = pready_o && psel_i && !pwrite_i;
  wire st_rd  = rd_ans && paddr_i == `RVS_OFS_CMD_STAT;
  wire er_rd  = rd_ans && paddr_i == `RVS_OFS_ERROR;
  wire fail   = media_o.req && media_i.done && (media_i.unc || media_i.idnf);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // properties
  a_drq_never: assert property (drq_o == 1'b0)
    else $error("drq raised");
  a_ready_one: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
    else $error("pready timing");
  a_slverr_only: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_req_hold: assert property (media_o.req && !media_i.done |=> $stable(media_o))
    else $error("media request moved");
  a_req_drop: assert property (media_o.req && media_i.done |=> !media_o.req)
    else $error("request not dropped");
  a_unc_stop: assert property (fail |=> !media_o.req [*8])
    else $error("continued after failure");
  a_busy_flag: assert property (st_rd && media_o.req |-> prdata_o[`RVS_ST_BSY])
    else $error("busy clear while reading");
  a_status_fix: assert property (st_rd && !prdata_o[`RVS_ST_BSY]
    |-> (prdata_o & 32'hFFFFFF7A) == 32'h00000050)
    else $error("final status bits");
  a_err_bits: assert property (er_rd |-> (prdata_o & 32'hFFFFFFAF) == 32'h0)
    else $error("error bits outside set");
  cover property (fail);
  cover property (st_rd && prdata_o[`RVS_ST_BSY]);
  cover property (irq_o);
endmodule // rvs_chk

bind rvs_top rvs_chk u_chk (.*);

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`include "rvs_cfg.svh"
module tb;
  import rvs_pkg::*;
  typedef struct {
    logic [7:0]  op, dh, cnt, k, left, st, er;
    logic [27:0] start, ea;
    logic [1:0]  kind, irq;
    logic [3:0]  dly;
  } rvs_row_s;
  logic           clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, drq, irq, rdy, serr, rerr;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata, rdat;
  logic [27:0]    bad = 28'h0;
  logic [1:0]     kind = 2'h0;
  logic [3:0]     dly = 4'h0;
  rvs_media_req_s mreq;
  rvs_media_rsp_s mrsp;
  rvs_row_s       r;
  int             mismatches = 0, compares = 0, cyc = 0;
  logic [7:0]     ra [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24};
  rvs_row_s rows [5] = '{
    '{8'h40, 8'h40, 8'h02, 8'h00, 8'h00, 8'h50, 8'h00, 28'h00000FF, 28'h0000100, 0, 1, 0},
    '{8'h41, 8'h50, 8'h04, 8'h02, 8'h02, 8'h51, 8'h40, 28'h5ABCDEF, 28'h5ABCDF1, 1, 2, 3},
    '{8'h40, 8'h40, 8'h03, 8'h00, 8'h03, 8'h51, 8'h10, 28'h0001000, 28'h0001000, 2, 2, 1},
    '{8'h41, 8'h00, 8'h03, 8'h01, 8'h00, 8'h54, 8'h00, 28'h2001001, 28'h2001003, 3, 1, 2},
    '{8'h40, 8'h40, 8'h00, 8'hFF, 8'h01, 8'h51, 8'h40, 28'h0000000, 28'h00000FF, 1, 2, 0}};
  always #50 clk = ~clk;
  rvs_top u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy),
    .pslverr_o(serr), .media_o(mreq), .media_i(mrsp), .drq_o(drq), .irq_o(irq));
  rvs_media_model u_media (.clk_i(clk), .rst_n_i(rst_n), .req_i(mreq), .bad_i(bad),
    .kind_i(kind), .dly_i(dly), .rsp_o(mrsp));
  // ==========================================================
  // bus and checks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (rdy !== 1'b1);
    rdat = prdata;
    rerr = serr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input string s, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rdat);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `RVS_OFS_CMD_STAT, 32'h0);
      n++;
    end
    while (rdat[`RVS_ST_BSY] !== 1'b0 && n < 1000);
  endtask
  // host loads task file then opcode
  task automatic run(input rvs_row_s x);
    kind <= x.kind;
    dly  <= x.dly;
    bad  <= x.start + 28'(x.k);
    apb(1'b1, `RVS_OFS_FEATURE, 32'hA5);
    apb(1'b1, `RVS_OFS_DRV_HEAD, 32'(x.dh | 8'(x.start[27:24])));
    apb(1'b1, `RVS_OFS_ADDR_HI, 32'(x.start[23:16]));
    apb(1'b1, `RVS_OFS_ADDR_MID, 32'(x.start[15:8]));
    apb(1'b1, `RVS_OFS_ADDR_LO, 32'(x.start[7:0]));
    apb(1'b1, `RVS_OFS_COUNT, 32'(x.cnt));
    apb(1'b1, `RVS_OFS_CMD_STAT, 32'(x.op));
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      summarize();
    end
  end
  // ==========================================================
  // sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rc(ra[i], "reset", 32'h0);
    rc(`RVS_OFS_CMD_STAT, "idle", 32'h50); // idle status
    rc(8'h28, "unmapped", 32'h0);
    chk("slverr", 32'h1, 32'(rerr));
    apb(1'b1, `RVS_OFS_CMD_STAT, 32'h20);
    rc(`RVS_OFS_CMD_STAT, "badop", 32'h50); // opcode filter
    foreach (rows[i])
    begin
      r = rows[i];
      run(r); // start
      idle(); // busy until done
      chk("status", 32'(r.st), rdat); // outcome
      chk("media", 32'({r.op == `RVS_OP_VERIFY_RTY, r.dh[`RVS_DH_LBA], r.dh[`RVS_DH_DRV]}),
          32'({mreq.retry, mreq.lba_mode, mreq.drive})); // media flags
      rc(`RVS_OFS_COUNT, "count", 32'(r.left)); // left count
      rc(`RVS_OFS_ADDR_LO, "lo", 32'(r.ea[7:0])); // address
      rc(`RVS_OFS_ADDR_MID, "mid", 32'(r.ea[15:8])); // address
      rc(`RVS_OFS_ADDR_HI, "hi", 32'(r.ea[23:16])); // address
      rc(`RVS_OFS_DRV_HEAD, "dh", 32'(r.dh | 8'(r.ea[27:24]))); // address
      rc(`RVS_OFS_ERROR, "error", 32'(r.er)); // error bits
      rc(`RVS_OFS_IRQ_STAT, "irqst", 32'(r.irq)); // event
      chk("irq_mask", 32'h0, 32'(irq)); // masked
      apb(1'b1, `RVS_OFS_IRQ_STAT, 32'h3);
    end
    apb(1'b1, `RVS_OFS_IRQ_MASK, 32'h2);
    run(rows[1]);
    apb(1'b1, `RVS_OFS_COUNT, 32'h77);
    idle();
    rc(`RVS_OFS_COUNT, "busy_wr", 32'h2); // busy lock
    chk("irq_on", 32'h1, 32'(irq)); // fail event
    apb(1'b1, `RVS_OFS_IRQ_STAT, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq_off", 32'h0, 32'(irq));
    chk("drq", 32'h0, 32'(drq)); // no data phase
    summarize();
  end
endmodule // tb
